//--- core/display_ram.sv
module display_ram (
	input  wire logic                             wr_clk,
	input  wire logic                             wr_en,
	input  wire logic [lcd_seg_pkg::ADDR_W-1:0]   wr_addr,
	input  wire logic [lcd_seg_pkg::NIB_W-1:0]    wr_data,
	input  wire logic                             rd_clk,
	input  wire logic [lcd_seg_pkg::ADDR_W-1:0]   rd_addr,
	output logic      [lcd_seg_pkg::NIB_W-1:0]    rd_data
);
	import lcd_seg_pkg::*;

	// contents are not reset: software reset must leave them intact
	logic [NIB_W-1:0] mem [RAM_DEPTH];

	always_ff @(posedge wr_clk) begin
		if (wr_en && (wr_addr <= RAM_LAST_ADDR)) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge rd_clk) begin
		if (rd_addr <= RAM_LAST_ADDR) begin
			rd_data <= mem[rd_addr];
		end else begin
			rd_data <= '0;
		end
	end

endmodule // display_ram

//--- core/lcd_seg_pkg.sv
package lcd_seg_pkg;

	localparam int          ADDR_W        = 6;
	localparam int          NIB_W         = 4;
	localparam int          RAM_DEPTH     = 50;
	localparam logic [5:0]  RAM_LAST_ADDR = 6'h31;
	localparam logic [5:0]  RAM_ADDR_RST  = 6'h00;
	localparam logic [7:0]  DEVICE_ADDR   = 8'h7c;
	localparam logic [3:0]  BIT_CNT_BYTE  = 4'h8;
	localparam logic [3:0]  BIT_CNT_NIB   = 4'h4;

	// command / data judge bit
	localparam int          CMD_JUDGE_BIT = 7;

	// drive_mode_cmd: bits 6..4 = 100
	localparam logic [2:0]  MODE_OPCODE   = 3'h4;
	localparam int          MODE_SHOW_BIT = 3;
	localparam int          MODE_BIAS_BIT = 2;
	localparam logic        DISP_EN_RST   = 1'b0;
	localparam logic        BIAS_HALF_RST = 1'b0;

	// address_set_cmd: bits 6..5 = 00
	localparam logic [1:0]  ADDR_SET_CODE = 2'h0;
	localparam logic [4:0]  ADDR_SET_MAX  = 5'h11;

	// ic_operation_cmd: bits 6..3 = 1101
	localparam logic [3:0]  ICOP_OPCODE   = 4'hd;
	localparam int          ICOP_MSB_BIT  = 2;
	localparam int          ICOP_SRST_BIT = 1;
	localparam int          ICOP_EXT_BIT  = 0;
	localparam logic        ADDR_MSB_RST  = 1'b0;
	localparam logic        EXT_CLK_RST   = 1'b0;

	typedef enum logic [2:0] {
		LINK_IDLE,
		LINK_ADDR,
		LINK_CMD,
		LINK_DATA,
		LINK_IGNORE
	} link_state_t;

	// ram address auto-increment with wrap at the last segment
	function automatic logic [5:0] next_ram_addr(input logic [5:0] a);
		if (a >= RAM_LAST_ADDR) begin
			return RAM_ADDR_RST;
		end
		return a + 6'h01;
	endfunction

endpackage

//--- core/lcd_segment_serial_cmd_ram.sv
// Overview of operation
// R1 - host opens with start, then device address
// R2 - bytes are eight bits; ack after eighth
// R3 - ack released after ninth; open-drain, low only
// R4 - ackless host drives low itself during ack
// R5 - first byte after address is a command
// R6 - judge bit picks next command or data
// R7 - after data begins, commands need new start
// R8 - start or stop drops a partial command
// R9 - wrong address: no ack, ignore until start
// R10 - display ram holds 50 four-bit entries
// R11 - byte stored as two nibbles, auto-increment
// R12 - address wraps from last entry to zero
// R13 - each nibble committed as it completes
// R14 - logic clock internal or external, selected
// R15 - software reset: display off, address zero
// R16 - display off blanks one frame then stops
// R17 - mode command sets bias and display enable
// R18 - address low bits from command, msb separate
// R19 - out-of-range address-set loads zero
// R20 - opcode decode for mode and address set
module lcd_segment_serial_cmd_ram (
	input  wire logic                             core_clk,
	input  wire logic                             reset,
	input  wire logic                             scan_clk,
	input  wire logic                             scl_in,
	input  wire logic                             sda_in,
	output logic                                  sda_out,
	output logic                                  sda_oe,
	output logic                                  display_enabled,
	output logic                                  bias_half,
	output logic                                  ext_clock_sel,
	output logic      [lcd_seg_pkg::ADDR_W-1:0]   scan_addr,
	output logic      [lcd_seg_pkg::NIB_W-1:0]    scan_nibble,
	output logic                                  outputs_active
);
	import lcd_seg_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and bus conditions

	logic        scl_meta_q;
	logic        scl_sync_q;
	logic        scl_prev_q;
	logic        sda_meta_q;
	logic        sda_sync_q;
	logic        sda_prev_q;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_cond;
	logic        stop_cond;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			scl_meta_q <= 1'b1;
			scl_sync_q <= 1'b1;
			scl_prev_q <= 1'b1;
			sda_meta_q <= 1'b1;
			sda_sync_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_meta_q <= scl_in;
			scl_sync_q <= scl_meta_q;
			scl_prev_q <= scl_sync_q;
			sda_meta_q <= sda_in;
			sda_sync_q <= sda_meta_q;
			sda_prev_q <= sda_sync_q;
		end
	end

	assign scl_rise   = scl_sync_q && !scl_prev_q;
	assign scl_fall   = !scl_sync_q && scl_prev_q;
	// sda moving while scl stays high
	assign start_cond = scl_sync_q && scl_prev_q && sda_prev_q && !sda_sync_q;
	assign stop_cond  = scl_sync_q && scl_prev_q && !sda_prev_q && sda_sync_q;

	////////////////////////////////////////////////////////////////////////////
	// byte receiver

	link_state_t state_q;
	logic [3:0]  bit_cnt_q;
	logic [7:0]  shift_q;
	logic [7:0]  shift_d;
	logic        ack_phase_q;
	logic        ack_want_q;
	logic        byte_done;
	logic        nib_done;

	assign shift_d   = {shift_q[6:0], sda_sync_q};
	assign byte_done = scl_rise && !ack_phase_q && (bit_cnt_q == BIT_CNT_BYTE - 4'h1); // R2
	assign nib_done  = scl_rise && !ack_phase_q && (bit_cnt_q == BIT_CNT_NIB - 4'h1);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			bit_cnt_q <= 4'h0;
			shift_q   <= 8'h00;
		end else if (start_cond || stop_cond) begin
			bit_cnt_q <= 4'h0; // R8
			shift_q   <= 8'h00;
		end else if (scl_rise && !ack_phase_q && (bit_cnt_q < BIT_CNT_BYTE)) begin
			bit_cnt_q <= bit_cnt_q + 4'h1;
			shift_q   <= shift_d;
		end else if (scl_fall && ack_phase_q) begin
			bit_cnt_q <= 4'h0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_q    <= LINK_IDLE;
			ack_want_q <= 1'b0;
		end else if (start_cond) begin
			state_q    <= LINK_ADDR; // R1 R9
			ack_want_q <= 1'b0;
		end else if (stop_cond) begin
			state_q    <= LINK_IDLE;
			ack_want_q <= 1'b0;
		end else if (byte_done) begin
			unique case (state_q)
				LINK_IDLE: begin
					ack_want_q <= 1'b0;
				end
				LINK_ADDR: begin
					if (shift_d == DEVICE_ADDR) begin
						state_q    <= LINK_CMD; // R5
						ack_want_q <= 1'b1;
					end else begin
						state_q    <= LINK_IGNORE; // R9
						ack_want_q <= 1'b0;
					end
				end
				LINK_CMD: begin
					ack_want_q <= 1'b1;
					if (shift_d[CMD_JUDGE_BIT]) begin
						state_q <= LINK_CMD; // R6
					end else begin
						state_q <= LINK_DATA; // R6
					end
				end
				LINK_DATA: begin
					state_q    <= LINK_DATA; // R7
					ack_want_q <= 1'b1;
				end
				LINK_IGNORE: begin
					ack_want_q <= 1'b0; // R9
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// acknowledge drive, open-drain

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ack_phase_q <= 1'b0;
			sda_oe      <= 1'b0;
			sda_out     <= 1'b0;
		end else if (start_cond || stop_cond) begin
			ack_phase_q <= 1'b0;
			sda_oe      <= 1'b0;
			sda_out     <= 1'b0;
		end else if (scl_fall && !ack_phase_q && (bit_cnt_q == BIT_CNT_BYTE)) begin
			ack_phase_q <= 1'b1;
			sda_oe      <= ack_want_q; // R2
			sda_out     <= 1'b0; // R3
		end else if (scl_fall && ack_phase_q) begin
			ack_phase_q <= 1'b0;
			sda_oe      <= 1'b0; // R3
			sda_out     <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// command decode and ram write path

	logic [5:0]  ram_addr_q;
	logic        addr_msb_q;
	logic        ram_wr_en;
	logic        is_mode_cmd;
	logic        is_addr_set_cmd;
	logic        is_icop_cmd;
	logic        cmd_exec;
	logic        soft_reset;

	assign cmd_exec     = byte_done && (state_q == LINK_CMD);
	assign is_mode_cmd  = (shift_d[6:4] == MODE_OPCODE); // R20
	assign is_addr_set_cmd = (shift_d[6:5] == ADDR_SET_CODE); // R20
	assign is_icop_cmd  = (shift_d[6:3] == ICOP_OPCODE);
	assign soft_reset   = cmd_exec && is_icop_cmd && shift_d[ICOP_SRST_BIT];
	// high nibble at four bits, low nibble at eight
	assign ram_wr_en    = (state_q == LINK_DATA) && (nib_done || byte_done); // R11 R13

	always_ff @(posedge core_clk) begin
		if (reset) begin
			display_enabled <= DISP_EN_RST;
			bias_half       <= BIAS_HALF_RST;
		end else if (soft_reset) begin
			display_enabled <= DISP_EN_RST; // R15
		end else if (cmd_exec && is_mode_cmd) begin
			display_enabled <= shift_d[MODE_SHOW_BIT]; // R17
			bias_half  <= shift_d[MODE_BIAS_BIT]; // R17
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			addr_msb_q    <= ADDR_MSB_RST;
			ext_clock_sel <= EXT_CLK_RST;
		end else if (cmd_exec && is_icop_cmd) begin
			// msb only; the ram address itself waits for address-set
			addr_msb_q    <= shift_d[ICOP_MSB_BIT]; // R18
			ext_clock_sel <= shift_d[ICOP_EXT_BIT]; // R14
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ram_addr_q <= RAM_ADDR_RST;
		end else if (soft_reset) begin
			ram_addr_q <= RAM_ADDR_RST; // R15
		end else if (cmd_exec && is_addr_set_cmd) begin
			if (shift_d[4:0] > ADDR_SET_MAX) begin
				ram_addr_q <= RAM_ADDR_RST; // R19
			end else begin
				ram_addr_q <= {addr_msb_q, shift_d[4:0]}; // R18
			end
		end else if (ram_wr_en) begin
			ram_addr_q <= next_ram_addr(ram_addr_q); // R11 R12
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// scan domain: reset and display-enable crossing

	logic        scan_rst_meta_q;
	logic        scan_rst_q;
	logic        en_meta_q;
	logic        en_sync_q;
	logic [5:0]  rd_addr_q;
	logic [5:0]  rd_addr_d1_q;
	logic [3:0]  rd_data;
	logic        blanking_q;

	always_ff @(posedge scan_clk) begin
		scan_rst_meta_q <= reset;
		scan_rst_q      <= scan_rst_meta_q;
	end

	always_ff @(posedge scan_clk) begin
		if (scan_rst_q) begin
			en_meta_q <= 1'b0;
			en_sync_q <= 1'b0;
		end else begin
			en_meta_q <= display_enabled;
			en_sync_q <= en_meta_q;
		end
	end

	display_ram u_ram (
		.wr_clk  (core_clk),
		.wr_en   (ram_wr_en),
		.wr_addr (ram_addr_q),
		.wr_data (shift_d[3:0]),
		.rd_clk  (scan_clk),
		.rd_addr (rd_addr_q),
		.rd_data (rd_data)
	); // R10

	////////////////////////////////////////////////////////////////////////////
	// frame scan, one pass of all entries per frame

	always_ff @(posedge scan_clk) begin
		if (scan_rst_q) begin
			rd_addr_q    <= RAM_ADDR_RST;
			rd_addr_d1_q <= RAM_ADDR_RST;
			scan_addr    <= RAM_ADDR_RST;
		end else begin
			rd_addr_q    <= next_ram_addr(rd_addr_q);
			rd_addr_d1_q <= rd_addr_q;
			scan_addr    <= rd_addr_d1_q; // aligned with registered ram data
		end
	end

	always_ff @(posedge scan_clk) begin
		if (scan_rst_q) begin
			scan_nibble <= '0;
		end else if (en_sync_q) begin
			scan_nibble <= rd_data; // R16
		end else begin
			scan_nibble <= '0; // R16
		end
	end

	// off data must cover a whole frame before the drivers stop
	always_ff @(posedge scan_clk) begin
		if (scan_rst_q) begin
			outputs_active <= 1'b0;
			blanking_q     <= 1'b0;
		end else if (en_sync_q) begin
			outputs_active <= 1'b1; // R16
			blanking_q     <= 1'b0;
		end else if (outputs_active) begin
			if (!blanking_q && (rd_addr_d1_q == RAM_ADDR_RST)) begin
				blanking_q <= 1'b1;
			// scan_addr, not the read pipe: entry 49 must still be shown active
			end else if (blanking_q && (scan_addr == RAM_LAST_ADDR)) begin
				outputs_active <= 1'b0; // R16
				blanking_q     <= 1'b0;
			end
		end
	end

endmodule // lcd_segment_serial_cmd_ram

//--- testbench/lcd_host_model.sv
module lcd_host_model (
	input  wire logic core_clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	timeunit 1ns;
	timeprecision 1ps;
	// set by the bench for a host that holds the ack slot low itself
	logic ackless = 1'b0;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// quarter bit of four cycles, above the three-cycle sync floor
	task automatic q;
		repeat (4) @(negedge core_clk);
	endtask
	task automatic start;
		sda_low = 1'b0;
		q();
		scl = 1'b1;
		q();
		sda_low = 1'b1;
		q();
		scl = 1'b0;
		q();
	endtask
	task automatic stop;
		sda_low = 1'b1;
		q();
		scl = 1'b1;
		q();
		sda_low = 1'b0;
		q();
	endtask
	// msb first; sda moves only while scl is low
	task automatic send(input logic [7:0] b, input int n, output logic ack);
		ack = 1'b0;
		for (int i = 0; i < n; i++) begin
			sda_low = !b[7-i];
			q();
			scl = 1'b1;
			q();
			q();
			scl = 1'b0;
			q();
		end
		if (n == 8) begin
			sda_low = ackless;
			q();
			scl = 1'b1;
			q();
			ack = !sda;
			q();
			scl = 1'b0;
			q();
		end
	endtask
endmodule // lcd_host_model

//--- testbench/lcd_seg_checker.sv
module lcd_seg_checker (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic display_enabled,
	input wire logic bias_half,
	input wire logic ext_clock_sel
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// five samples cover the pin sync lag
	sequence scl_high_run;
		scl_in [*5];
	endsequence
	chk_sda_never_high: assert property (sda_out == 1'b0)
		else $error("sda driven high");
	chk_ack_rise_low: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in))
		else $error("ack raised with scl high");
	chk_ack_fall_low: assert property ($fell(sda_oe) |-> !scl_in)
		else $error("ack dropped with scl high");
	chk_ack_held_high: assert property (scl_high_run |-> $stable(sda_oe))
		else $error("ack moved while scl high");
	chk_ack_release_due: assert property (sda_oe && $fell(scl_in) |-> ##[1:6] !sda_oe)
		else $error("ack not released after ninth clock");
	chk_display_at_sample: assert property ($changed(display_enabled) |-> scl_in)
		else $error("display state moved off a bit sample");
	chk_bias_at_sample: assert property ($changed(bias_half) |-> scl_in)
		else $error("bias moved off a bit sample");
	chk_ext_at_sample: assert property ($changed(ext_clock_sel) |-> scl_in)
		else $error("clock select moved off a bit sample");
endmodule // lcd_seg_checker
bind lcd_segment_serial_cmd_ram lcd_seg_checker u_chk (.core_clk(core_clk), .reset(reset),
	.scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .display_enabled(display_enabled),
	.bias_half(bias_half), .ext_clock_sel(ext_clock_sel));

//--- testbench/lcd_segment_serial_cmd_ram_tb.sv
module lcd_segment_serial_cmd_ram_tb;
	import lcd_seg_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic scan_clk = 1'b0;
	logic reset = 1'b1;
	logic scl, host_low, sda, sda_out, sda_oe, ack;
	logic display_enabled, bias_half, ext_clock_sel, outputs_active;
	logic [ADDR_W-1:0] scan_addr;
	logic [NIB_W-1:0] scan_nibble;
	int err_count = 0;
	int n_tests = 0;
	always #25 core_clk = ~core_clk;
	initial begin
		#1.3;
		forever #3 scan_clk = ~scan_clk;
	end
	// pull-up for the shared data line
	assign sda = (host_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
	lcd_host_model host (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(host_low));
	lcd_segment_serial_cmd_ram dut (.core_clk(core_clk), .reset(reset), .scan_clk(scan_clk),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.display_enabled(display_enabled), .bias_half(bias_half), .ext_clock_sel(ext_clock_sel),
		.scan_addr(scan_addr), .scan_nibble(scan_nibble), .outputs_active(outputs_active));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] b, input logic exp_ack);
		host.send(b, 8, ack);
		chk(ack, exp_ack, "ack");
	endtask
	task automatic ram(input logic [5:0] a, input logic [3:0] exp);
		int k;
		k = 0;
		@(negedge scan_clk);
		while (scan_addr !== a && k < 200) begin
			@(negedge scan_clk);
			k++;
		end
		chk(scan_nibble, exp, "ram");
	endtask
	task automatic tally_and_finish;
		$display("tests %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		// about two and a half times the expected run of some 165 us
		#400000;
		err_count++;
		$display("ERROR %0t: watchdog", $time);
		tally_and_finish();
	end
	initial begin
		repeat (2) @(negedge core_clk);
		reset = 1'b0;
		repeat (4) @(negedge core_clk);
		chk(display_enabled, 1'b0, "display reset");
		chk(bias_half, 1'b0, "bias reset");
		host.start();
		wr(8'h7c, 1'b1);
		wr(8'hcc, 1'b1);
		chk(display_enabled, 1'b1, "display set");
		chk(bias_half, 1'b1, "bias");
		wr(8'hed, 1'b1);
		chk(ext_clock_sel, 1'b1, "ext");
		wr(8'h11, 1'b1);
		wr(8'ha5, 1'b1);
		wr(8'h3c, 1'b1);
		// a mode-set pattern sent as data must land in ram, not change bias
		wr(8'hc8, 1'b1);
		host.stop();
		chk(bias_half, 1'b1, "data mode");
		ram(6'h31, 4'ha);
		ram(6'h00, 4'h5);
		ram(6'h02, 4'hc);
		ram(6'h03, 4'hc);
		ram(6'h04, 4'h8);
		chk(outputs_active, 1'b1, "active");
		$display("test command and data done");
		host.start();
		wr(8'h7e, 1'b0);
		wr(8'hc0, 1'b0);
		host.stop();
		chk(display_enabled, 1'b1, "ignored");
		host.start();
		wr(8'h7c, 1'b1);
		host.send(8'hc0, 4, ack);
		host.start();
		wr(8'h7c, 1'b1);
		chk(display_enabled, 1'b1, "partial");
		wr(8'he8, 1'b1);
		chk(ext_clock_sel, 1'b0, "ext off");
		wr(8'h1f, 1'b1);
		wr(8'h69, 1'b1);
		host.stop();
		ram(6'h00, 4'h6);
		ram(6'h01, 4'h9);
		$display("test refusals done");
		host.start();
		wr(8'h7c, 1'b1);
		wr(8'h6a, 1'b1);
		chk(display_enabled, 1'b0, "soft reset");
		wr(8'h7e, 1'b1);
		host.start();
		wr(8'h7c, 1'b1);
		wr(8'hc8, 1'b1);
		host.stop();
		chk(bias_half, 1'b0, "third bias");
		ram(6'h00, 4'h7);
		ram(6'h01, 4'he);
		ram(6'h02, 4'hc);
		$display("test soft reset done");
		host.ackless = 1'b1;
		host.start();
		wr(8'h7c, 1'b1);
		wr(8'h40, 1'b1);
		host.stop();
		host.ackless = 1'b0;
		chk(display_enabled, 1'b0, "display off");
		// three frames of fifty entries
		repeat (150) @(negedge scan_clk);
		chk(outputs_active, 1'b0, "outputs stop");
		chk(scan_nibble, 4'h0, "blank");
		$display("test display off done");
		tally_and_finish();
	end
endmodule // lcd_segment_serial_cmd_ram_tb
